/* src/pmbw_defs.vh */
`ifndef PMBW_DEFS_VH
`define PMBW_DEFS_VH

`define PMBW_DATA_W        32
`define PMBW_BE_W          4
`define PMBW_CNT_W         16

`define PMBW_ST_IDLE       2'h0
`define PMBW_ST_DATA       2'h1
`define PMBW_ST_RELEASE    2'h2

`define PMBW_CNT_RST       16'h0000
`define PMBW_DATA_RST      32'h00000000
`define PMBW_BE_RST        4'hF

`endif

/* src/pmbw_burst_counter.v */
`include "pmbw_defs.vh"

module pmbw_burst_counter #(
    parameter CNT_W = `PMBW_CNT_W
) (
    input  wire             clk_i,      // PCI clock
    input  wire             rstn_i,     // Synchronous reset, active low
    input  wire             load_i,     // Load a new burst length
    input  wire [CNT_W-1:0] len_i,      // Burst length in doublewords
    input  wire             dec_i,      // One data phase has completed
    output wire [CNT_W-1:0] count_o,    // Remaining doublewords
    output wire             last_o,     // Exactly one doubleword remains
    output wire             zero_o      // Nothing remains
);

    reg  [CNT_W-1:0] count_q;
    reg  [CNT_W-1:0] count_d;

    always @* begin
        count_d = count_q;
        if (load_i) begin
            count_d = len_i;
        end else if (dec_i && (count_q != {CNT_W{1'b0}})) begin
            count_d = count_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            count_q <= {CNT_W{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    assign count_o = count_q;
    assign last_o  = (count_q == {{(CNT_W-1){1'b0}}, 1'b1});
    assign zero_o  = (count_q == {CNT_W{1'b0}});

endmodule // pmbw_burst_counter

/* src/pmbw_burst_write.v */
`include "pmbw_defs.vh"

module pmbw_burst_write #(
    parameter DATA_W = `PMBW_DATA_W,
    parameter BE_W   = `PMBW_BE_W,
    parameter CNT_W  = `PMBW_CNT_W
) (
    input  wire              clk_i,                   // PCI clock, 250 MHz in this build
    input  wire              rstn_i,                  // Synchronous reset, active low
    // Local master side.
    input  wire              start_i,                 // Pulse: begin the data phases of a burst write
    input  wire [CNT_W-1:0]  burst_len_i,             // Doublewords in the burst, sampled with start_i
    input  wire              local_source_ready_n_i,  // Local master can supply a word, active low
    input  wire [DATA_W-1:0] local_data_in_i,         // Local doubleword offered
    input  wire [BE_W-1:0]   local_byte_lanes_in_i,   // Byte enables of the offered word, active low
    output wire              local_word_taken_n_o,    // Offered word was taken, active low
    output wire [CNT_W-1:0]  remaining_burst_count_o, // Data phases still to complete
    output wire              busy_o,                  // Burst in progress
    // PCI side, each shared pin as input, output and output enable; trdy# as input only.
    input  wire              framen_i,                // frame# as seen on the bus
    output wire              framen_o,                // frame# driven value
    output wire              framen_oe_o,             // High while frame# is driven
    input  wire              irdyn_i,                 // irdy# as seen on the bus
    output wire              irdyn_o,                 // irdy# driven value
    output wire              irdyn_oe_o,              // High while irdy# is driven
    input  wire              trdyn_i,                 // trdy# from the target, PCI clock domain
    input  wire [DATA_W-1:0] ad_i,                    // ad as seen on the bus
    output wire [DATA_W-1:0] ad_o,                    // ad driven value
    output wire              ad_oe_o,                 // High while ad is driven
    input  wire [BE_W-1:0]   cben_i,                  // c/be# as seen on the bus
    output wire [BE_W-1:0]   cben_o,                  // c/be# driven value
    output wire              cben_oe_o                // High while c/be# is driven
);

    // The bus-side pins are outputs of this master during the data phases; their
    // input copies are kept only so that the pad wiring stays uniform.
    localparam [1:0] ST_IDLE    = `PMBW_ST_IDLE;
    localparam [1:0] ST_DATA    = `PMBW_ST_DATA;
    localparam [1:0] ST_RELEASE = `PMBW_ST_RELEASE;

    reg  [1:0]        state_q;
    reg  [1:0]        state_d;
    reg               frame_q;      // High means frame# asserted
    reg               frame_d;
    reg               irdy_q;       // High means irdy# asserted
    reg               irdy_d;
    reg               drive_q;      // Output enables of frame, ad, cbe (irdy has irdy_drive_q)
    reg               drive_d;
    reg               irdy_drive_q; // irdy# is driven one cycle longer than frame#
    reg               irdy_drive_d;
    reg  [DATA_W-1:0] ad_q;
    reg  [DATA_W-1:0] ad_d;
    reg  [BE_W-1:0]   cbe_q;
    reg  [BE_W-1:0]   cbe_d;
    reg               word_valid_q; // ad_q/cbe_q hold a word not yet accepted
    reg               word_valid_d;
    reg               taken_q;      // High means the local word was taken last edge
    reg               taken_d;

    wire              phase_done;
    wire              local_ready;
    wire              cnt_load;
    wire              cnt_last;
    wire              cnt_zero;
    wire [CNT_W-1:0]  cnt_value;

    assign local_ready = ~local_source_ready_n_i;
    // A data phase ends only on the edge where both ready strobes are low.
    assign phase_done  = (state_q == ST_DATA) && irdy_q && ~trdyn_i;
    assign cnt_load    = (state_q == ST_IDLE) && start_i;

    pmbw_burst_counter #(
        .CNT_W   (CNT_W)
    ) u_counter (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .load_i  (cnt_load),
        .len_i   (burst_len_i),
        .dec_i   (phase_done),
        .count_o (cnt_value),
        .last_o  (cnt_last),
        .zero_o  (cnt_zero)
    );

    // Frame stays asserted until the final data phase is under way, as the bus
    // requires frame# to fall while irdy# is asserted on the last phase.
    function frame_needed;
        input         last;
        input         irdy;
        input         done;
        begin
            frame_needed = ~(last && (irdy || done));
        end
    endfunction

    always @* begin
        state_d      = state_q;
        frame_d      = frame_q;
        irdy_d       = irdy_q;
        drive_d      = drive_q;
        irdy_drive_d = irdy_drive_q;
        ad_d         = ad_q;
        cbe_d        = cbe_q;
        word_valid_d = word_valid_q;
        taken_d      = 1'b0;
        case (state_q)
            ST_IDLE: begin
                frame_d      = 1'b0;
                irdy_d       = 1'b0;
                drive_d      = 1'b0;
                irdy_drive_d = 1'b0;
                word_valid_d = 1'b0;
                if (start_i && (burst_len_i != {CNT_W{1'b0}})) begin
                    state_d      = ST_DATA;
                    frame_d      = 1'b1;
                    drive_d      = 1'b1;
                    irdy_drive_d = 1'b1;
                    if (local_ready) begin
                        ad_d         = local_data_in_i;
                        cbe_d        = local_byte_lanes_in_i;
                        word_valid_d = 1'b1;
                        taken_d      = 1'b1;
                        irdy_d       = 1'b1;
                        // A one-word burst starts on its final phase, so frame# must not be raised with irdy#.
                        frame_d      = frame_needed(burst_len_i == {{(CNT_W-1){1'b0}}, 1'b1}, 1'b1, 1'b0);
                    end
                end
            end
            ST_DATA: begin
                if (phase_done) begin
                    if (cnt_last) begin
                        // Final word accepted: give the bus back.
                        state_d      = ST_RELEASE;
                        frame_d      = 1'b0;
                        irdy_d       = 1'b0;
                        drive_d      = 1'b0;
                        word_valid_d = 1'b0;
                    end else if (local_ready) begin
                        // Next word follows at once; burst continues.
                        ad_d         = local_data_in_i;
                        cbe_d        = local_byte_lanes_in_i;
                        word_valid_d = 1'b1;
                        taken_d      = 1'b1;
                        irdy_d       = 1'b1;
                        frame_d      = frame_needed(cnt_value == {{(CNT_W-2){1'b0}}, 2'h2}, 1'b1, 1'b0);
                    end else begin
                        // Local side stalled: insert master wait states.
                        word_valid_d = 1'b0;
                        irdy_d       = 1'b0;
                        frame_d      = 1'b1;
                    end
                end else if (!word_valid_q) begin
                    if (local_ready) begin
                        ad_d         = local_data_in_i;
                        cbe_d        = local_byte_lanes_in_i;
                        word_valid_d = 1'b1;
                        taken_d      = 1'b1;
                        irdy_d       = 1'b1;
                        frame_d      = frame_needed(cnt_last, 1'b1, 1'b0);
                    end
                end else begin
                    // Waiting on the target; irdy# must not be withdrawn.
                    irdy_d  = 1'b1;
                    frame_d = frame_needed(cnt_last, 1'b1, 1'b0);
                end
            end
            ST_RELEASE: begin
                // irdy# was driven high for this turnaround cycle, then floats.
                irdy_drive_d = 1'b0;
                state_d      = ST_IDLE;
            end
            default: begin
                state_d      = ST_IDLE;
                frame_d      = 1'b0;
                irdy_d       = 1'b0;
                drive_d      = 1'b0;
                irdy_drive_d = 1'b0;
                word_valid_d = 1'b0;
            end
        endcase
        if (cnt_zero && (state_q == ST_DATA) && !phase_done) begin
            state_d = ST_IDLE;
        end
    end

    always @(posedge clk_i) begin
        if (!rstn_i) begin
            state_q      <= ST_IDLE;
            frame_q      <= 1'b0;
            irdy_q       <= 1'b0;
            drive_q      <= 1'b0;
            irdy_drive_q <= 1'b0;
            ad_q         <= `PMBW_DATA_RST;
            cbe_q        <= `PMBW_BE_RST;
            word_valid_q <= 1'b0;
            taken_q      <= 1'b0;
        end else begin
            state_q      <= state_d;
            frame_q      <= frame_d;
            irdy_q       <= irdy_d;
            drive_q      <= drive_d;
            irdy_drive_q <= irdy_drive_d;
            ad_q         <= ad_d;
            cbe_q        <= cbe_d;
            word_valid_q <= word_valid_d;
            taken_q      <= taken_d;
        end
    end

    assign framen_o                = ~frame_q;
    assign framen_oe_o             = drive_q;
    assign irdyn_o                 = ~irdy_q;
    assign irdyn_oe_o              = irdy_drive_q;
    assign ad_o                    = ad_q;
    assign ad_oe_o                 = drive_q;
    assign cben_o                  = cbe_q;
    assign cben_oe_o               = drive_q;
    assign local_word_taken_n_o    = ~taken_q;
    assign remaining_burst_count_o = cnt_value;
    assign busy_o                  = (state_q != ST_IDLE);

endmodule // pmbw_burst_write

/* sim/pmbw_sva.sv */
module pmbw_sva #(parameter CNT_W = 16) (
    input wire logic             clk_i, // Clock.
    input wire logic             rstn_i, // Reset.
    input wire logic             local_source_ready_n_i, // Word offered.
    input wire logic             local_word_taken_n_o, // Word taken.
    input wire logic [CNT_W-1:0] remaining_burst_count_o, // Phases left.
    input wire logic             busy_o, // Busy.
    input wire logic             framen_o, // Frame.
    input wire logic             irdyn_o, // Master ready.
    input wire logic             irdyn_oe_o, // Master ready driven.
    input wire logic             trdyn_i // Target ready.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    wire rdy  = !local_source_ready_n_i;
    wire irdy = irdyn_oe_o && !irdyn_o;
    wire more = remaining_burst_count_o > 1;
    sequence done_s;
        irdy && !trdyn_i;
    endsequence
    frame_hold_a: assert property (irdy && more |-> !framen_o)
        else $error("frame dropped early");
    irdy_drive_a: assert property (!framen_o |-> irdyn_oe_o)
        else $error("irdy not driven in frame");
    no_take_a: assert property (local_source_ready_n_i |=> local_word_taken_n_o)
        else $error("word taken while not offered");
    count_dec_a: assert property (done_s |=> remaining_burst_count_o == $past(remaining_burst_count_o) - 1)
        else $error("count not decremented");
    count_hold_a: assert property (busy_o && !(irdy && !trdyn_i) |=> $stable(remaining_burst_count_o))
        else $error("count moved without phase");
    irdy_keep_a: assert property (irdy && more && rdy |=> irdy)
        else $error("irdy dropped");
    word_ack_a: assert property (done_s ##0 more && rdy |=> !local_word_taken_n_o)
        else $error("word not acknowledged");
    word_once_a: assert property (done_s ##0 !more |=> !irdy ##1 !irdyn_oe_o)
        else $error("last phase not closed");
    frame_last_a: assert property (irdy && remaining_burst_count_o == 1 |-> framen_o)
        else $error("frame still held on final phase");
endmodule // pmbw_sva

bind pmbw_burst_write pmbw_sva #(.CNT_W(CNT_W)) u_sva (.clk_i, .rstn_i, .local_source_ready_n_i,
    .local_word_taken_n_o, .remaining_burst_count_o, .busy_o, .framen_o, .irdyn_o, .irdyn_oe_o, .trdyn_i);

/* sim/pmbw_tgt_model.sv */
module pmbw_tgt_model (
    input  wire logic        clk_i, // Clock.
    input  wire logic        rstn_i, // Reset, active low.
    input  wire logic        frm_n_i, // Frame value.
    input  wire logic        frm_oe_i, // Frame driven.
    input  wire logic        irdy_n_i, // Master ready value.
    input  wire logic        irdy_oe_i, // Master ready driven.
    input  wire logic [31:0] ad_i, // Data lines.
    input  wire logic [3:0]  cbe_n_i, // Byte enables.
    input  wire logic [3:0]  wait_i, // Wait states per phase.
    output logic             trdy_n_o = 1'b1 // Target ready, active low.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [35:0] seen_q[$];
    int          cnt = 0;
    wire         act  = (frm_oe_i && !frm_n_i) || (irdy_oe_i && !irdy_n_i);
    wire         done = irdy_oe_i && !irdy_n_i && !trdy_n_o;
    // With no wait states, ready is withdrawn on the edge after the master lets go of frame and irdy, so it lingers one cycle past the last phase.
    always @(posedge clk_i) begin
        if (!rstn_i || !act) begin
            cnt = 0;
            trdy_n_o <= 1'b1;
        end else begin
            if (done) begin
                seen_q.push_back({cbe_n_i, ad_i});
                cnt = 0;
            end else if (trdy_n_o) begin
                cnt++;
            end
            trdy_n_o <= cnt < wait_i;
        end
    end
endmodule // pmbw_tgt_model

/* sim/pci_master_burst_write_path_test.sv */
module pci_master_burst_write_path_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rstn_i = 1'b0, go = 1'b0, rdy_n = 1'b1;
    logic [15:0] len = 16'h0000, cnt;
    logic [35:0] lw = 36'hF00000000;
    logic [31:0] ad;
    logic [3:0]  wt = 4'h0, cbe;
    logic        tk_n, busy, fr, fr_oe, ir, ir_oe, ad_oe, cbe_oe, tr;
    int          error_cnt = 0, n_tests = 0, cyc = 0;
    initial forever #2 clk_i = ~clk_i;
    pmbw_burst_write dut (.clk_i, .rstn_i, .start_i(go), .burst_len_i(len), .local_source_ready_n_i(rdy_n),
        .local_data_in_i(lw[31:0]), .local_byte_lanes_in_i(lw[35:32]), .local_word_taken_n_o(tk_n),
        .remaining_burst_count_o(cnt), .busy_o(busy), .framen_i(fr | !fr_oe), .framen_o(fr),
        .framen_oe_o(fr_oe), .irdyn_i(ir | !ir_oe), .irdyn_o(ir), .irdyn_oe_o(ir_oe), .trdyn_i(tr),
        .ad_i(ad_oe ? ad : ~ad), .ad_o(ad), .ad_oe_o(ad_oe), .cben_i(cbe_oe ? cbe : ~cbe), .cben_o(cbe),
        .cben_oe_o(cbe_oe));
    pmbw_tgt_model tgt (.clk_i, .rstn_i, .frm_n_i(fr), .frm_oe_i(fr_oe), .irdy_n_i(ir), .irdy_oe_i(ir_oe),
        .ad_i(ad), .cbe_n_i(cbe), .wait_i(wt), .trdy_n_o(tr));
    task automatic chk(input string what, input logic [35:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [35:0] word(input int n, k);
        return {4'(k) ^ 4'h5, 32'h5A000000 + 32'(n * 256 + k)};
    endfunction
    // A stalling source idles one cycle after each hand-over; an idle source shows inverted data.
    task automatic run_burst(input int n, input int w, input bit stall, input bit again);
        int k = 0;
        tgt.seen_q.delete();
        wt = 4'(w);
        len = 16'(n);
        go = 1'b1;
        {rdy_n, lw} = {1'b0, word(n, 0)};
        for (int t = 0; t < 400 && (t < 2 || busy === 1'b1); t++) begin
            @(negedge clk_i);
            go = again && t == 3;
            if (tk_n === 1'b0)
                k++;
            rdy_n = k >= n || (stall && tk_n === 1'b0);
            lw = rdy_n ? ~word(n, k) : word(n, k);
        end
        chk("busy", 36'h0, busy);
        chk("count", 36'h0, cnt);
        chk("words", 36'(n), 36'(tgt.seen_q.size()));
        for (k = 0; k < n; k++)
            chk("word", word(n, k), tgt.seen_q[k]);
    endtask
    initial begin
        repeat (16) @(negedge clk_i);
        rstn_i = 1'b1;
        chk("idle", 36'h07F, {fr_oe, ir_oe, ad_oe, cbe_oe, busy, tk_n, fr, ir, cbe});
        run_burst(4, 0, 1'b0, 1'b0);
        run_burst(3, 2, 1'b0, 1'b1);
        run_burst(3, 0, 1'b1, 1'b0);
        run_burst(1, 1, 1'b0, 1'b0);
        go = 1'b1;
        len = 16'h0005;
        repeat (3) @(negedge clk_i);
        go = 1'b0;
        rstn_i = 1'b0;
        @(negedge clk_i);
        chk("reset", 36'h07F, {fr_oe, ir_oe, ad_oe, cbe_oe, busy, tk_n, fr, ir, cbe});
        rstn_i = 1'b1;
        run_burst(2, 0, 1'b0, 1'b0);
        conclude();
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            conclude();
        end
    end
endmodule // pci_master_burst_write_path_test
